// File: src/serial_access_pkg.sv
// constants, register map and timing for the serial register access port
package serial_access_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int HDR_BITS = 16;
    localparam int FRAME_BITS = 24;
    localparam int NREG = 44;
    // map of implemented byte addresses, reset values and writability
    localparam logic [14:0] REG_ADDR [NREG] = '{
        15'h0000, 15'h0002, 15'h0003, 15'h0004, 15'h000C, 15'h000D, 15'h0010, 15'h0029,
        15'h002A, 15'h002B, 15'h002C, 15'h0030, 15'h0031, 15'h0032, 15'h0033, 15'h0038,
        15'h003B, 15'h0048, 15'h0060, 15'h0061, 15'h0062, 15'h0064, 15'h0068, 15'h006A,
        15'h006B, 15'h006C, 15'h006E, 15'h0070, 15'h0071, 15'h007A, 15'h007B, 15'h007C,
        15'h007E, 15'h007F, 15'h009D, 15'h0160, 15'h0200, 15'h0201, 15'h0202, 15'h0203,
        15'h0204, 15'h0205, 15'h0206, 15'h0207};
    // identity bytes at 0x3, 0x4, 0xC, 0xD: values are arbitrary
    localparam logic [7:0] REG_RST [NREG] = '{
        8'h30, 8'h00, 8'h5A, 8'h21, 8'h34, 8'h12, 8'h00, 8'h00,
        8'h00, 8'h11, 8'h00, 8'h00, 8'hA0, 8'h00, 8'hA0, 8'h00,
        8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h61, 8'h00,
        8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h1F, 8'h01,
        8'h03, 8'h00, 8'h00, 8'h00};
    localparam logic REG_RW [NREG] = '{
        1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
        1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
        1'b1, 1'b1, 1'b1, 1'b1};
    localparam int IDX_IFACE_CFG = 0;
    localparam int IDX_USER_OPT = 6;
    localparam int ADDRESS_DIRECTION_SELECT_BIT = 5;
    localparam int STREAM_OFF_BIT = 0;
    // host command registers
    localparam logic [2:0] HOST_CTRL = 3'h0;
    localparam logic [2:0] HOST_ADDR = 3'h1;
    localparam logic [2:0] HOST_TXDATA = 3'h2;
    localparam logic [2:0] HOST_LEN = 3'h3;
    localparam logic [2:0] HOST_STATUS = 3'h4;
    localparam logic [2:0] HOST_RXDATA = 3'h5;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_READ_BIT = 1;
    localparam int STATUS_BUSY_BIT = 0;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCLK_PERIOD_NS = 125;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// File: src/serial_link_if.sv
// four-wire serial link between host and device
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
    logic sclk;
    logic serial_chip_select_n;
    logic serial_data_in;
    logic serial_data_out;
    logic serial_data_out_en_n;
    wire sdo_pin;
    // released pin reads as its pull-up level
    assign sdo_pin = serial_data_out_en_n ? 1'b1 : serial_data_out;
    modport device (
        input sclk,
        input serial_chip_select_n,
        input serial_data_in,
        output serial_data_out,
        output serial_data_out_en_n
    );
    modport host (
        output sclk,
        output serial_chip_select_n,
        output serial_data_in,
        input sdo_pin
    );
endinterface
`default_nettype wire

// File: src/serial_port_host.sv
// serial host: builds frames from command registers
`timescale 1ns/10ps
`default_nettype none
module serial_port_host #(
    parameter int HALF_CYC = serial_access_pkg::SCLK_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic [2:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [15:0] cmd_rdata,
    serial_link_if.host link
);
    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_LEAD = 5'h02, H_HIGH = 5'h04, H_LOW = 5'h08, H_TRAIL = 5'h10
    } host_state_t;
    host_state_t state_q;
    logic [14:0] addr_q;
    logic [7:0] txd_q;
    logic [7:0] len_q;
    logic [7:0] rxd_q;
    logic [23:0] shift_q;
    logic [11:0] sent_q;
    logic [11:0] total_q;
    logic [7:0] div_q;
    logic sclk_q;
    logic cs_n_q;
    logic [1:0] sdo_s;
    logic half_done;
    logic start;

    assign half_done = (div_q == 8'(HALF_CYC - 1));
    assign start = cmd_wr && (cmd_addr == serial_access_pkg::HOST_CTRL)
        && cmd_wdata[serial_access_pkg::CTRL_START_BIT] && (state_q == H_IDLE);
    assign link.sclk = sclk_q;
    assign link.serial_chip_select_n = cs_n_q;
    assign link.serial_data_in = shift_q[23];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sdo_s <= 2'h0;
        end else if (ce) begin
            sdo_s <= {sdo_s[0], link.sdo_pin};
        end
    end

    // command registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_q <= 15'h0000;
            txd_q <= 8'h00;
            len_q <= 8'h00;
        end else if (ce && cmd_wr) begin
            if (cmd_addr == serial_access_pkg::HOST_ADDR) begin
                addr_q <= cmd_wdata[14:0];
            end else if (cmd_addr == serial_access_pkg::HOST_TXDATA) begin
                txd_q <= cmd_wdata[7:0];
            end else if (cmd_addr == serial_access_pkg::HOST_LEN) begin
                len_q <= cmd_wdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_rdata <= 16'h0000;
        end else if (ce) begin
            if (!cmd_rd) begin
                cmd_rdata <= 16'h0000;
            end else if (cmd_addr == serial_access_pkg::HOST_ADDR) begin
                cmd_rdata <= {1'b0, addr_q};
            end else if (cmd_addr == serial_access_pkg::HOST_TXDATA) begin
                cmd_rdata <= {8'h00, txd_q};
            end else if (cmd_addr == serial_access_pkg::HOST_LEN) begin
                cmd_rdata <= {8'h00, len_q};
            end else if (cmd_addr == serial_access_pkg::HOST_STATUS) begin
                cmd_rdata <= {15'h0000, state_q != H_IDLE};
            end else if (cmd_addr == serial_access_pkg::HOST_RXDATA) begin
                cmd_rdata <= {8'h00, rxd_q};
            end else begin
                cmd_rdata <= 16'h0000;
            end
        end
    end

    // frame sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= H_IDLE;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            shift_q <= 24'h000000;
            sent_q <= 12'h000;
            total_q <= 12'h000;
            div_q <= 8'h00;
            rxd_q <= 8'h00;
        end else if (ce) begin
            div_q <= half_done ? 8'h00 : div_q + 8'h01;
            case (state_q)
                H_IDLE: begin
                    div_q <= 8'h00;
                    if (start) begin
                        shift_q <= {cmd_wdata[serial_access_pkg::CTRL_READ_BIT], addr_q, txd_q};
                        sent_q <= 12'h000;
                        total_q <= 12'(serial_access_pkg::FRAME_BITS) + {1'b0, len_q, 3'h0};
                        cs_n_q <= 1'b0;
                        state_q <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (half_done) begin
                        sclk_q <= 1'b1;
                        rxd_q <= {rxd_q[6:0], sdo_s[1]};
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        sclk_q <= 1'b0;
                        sent_q <= sent_q + 12'h001;
                        if (sent_q + 12'h001 == total_q) begin
                            state_q <= H_TRAIL;
                        end else begin
                            state_q <= H_LOW;
                            if (sent_q[2:0] == 3'h7 && sent_q >= 12'h017) begin
                                shift_q <= {txd_q, 16'h0000};
                            end else begin
                                shift_q <= {shift_q[22:0], 1'b0};
                            end
                        end
                    end
                end
                H_TRAIL: begin
                    if (half_done) begin
                        cs_n_q <= 1'b1;
                        state_q <= H_IDLE;
                    end
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: src/serial_port_device.sv
// serial register access port: device end with register file
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module serial_port_device #(
    parameter int NREG = serial_access_pkg::NREG
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    serial_link_if.device link,
    output logic [7:0] interface_config,
    output logic [7:0] user_serial_options,
    output logic wr_pulse,
    output logic [14:0] wr_addr,
    output logic [7:0] wr_data
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR = 4'h2,
        ST_DATA = 4'h4,
        ST_HOLD = 4'h8
    } dev_state_t;

    dev_state_t state_q;
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic sclk_d;
    logic [3:0] cnt_q;
    logic [14:0] hdr_q;
    logic rd_q;
    logic [14:0] addr_q;
    logic [6:0] rx_q;
    logic [7:0] tx_q;
    logic [7:0] regs_q [NREG];
    logic rise;
    logic fall;
    logic cs_act;
    logic [15:0] hdr_next;
    logic [7:0] byte_next;
    logic asc;
    logic stream_off;
    logic [14:0] addr_step;
    logic wr_fire;
    logic byte_end;

    // link pins pass two flops before use
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sclk_s <= 2'h0;
            cs_s <= 2'h3;
            sdi_s <= 2'h0;
            sclk_d <= 1'b0;
        end else if (ce) begin
            sclk_s <= {sclk_s[0], link.sclk};
            cs_s <= {cs_s[0], link.serial_chip_select_n};
            sdi_s <= {sdi_s[0], link.serial_data_in};
            sclk_d <= sclk_s[1];
        end
    end

    // edges found from the sampled clock, no rate limit
    assign rise = sclk_s[1] & ~sclk_d;
    assign fall = ~sclk_s[1] & sclk_d;
    assign cs_act = ~cs_s[1];

    assign hdr_next = {hdr_q, sdi_s[1]};
    assign byte_next = {rx_q, sdi_s[1]};
    assign asc = regs_q[serial_access_pkg::IDX_IFACE_CFG][serial_access_pkg::ADDRESS_DIRECTION_SELECT_BIT];
    assign stream_off =
        regs_q[serial_access_pkg::IDX_USER_OPT][serial_access_pkg::STREAM_OFF_BIT];
    assign addr_step = asc ? addr_q + 15'h0001 : addr_q - 15'h0001;
    assign byte_end = (state_q == ST_DATA) && cs_act && rise && (cnt_q == 4'h7);
    assign wr_fire = byte_end && !rd_q;

    // read lookup over the implemented addresses, unmapped reads zero
    function automatic logic [7:0] rd_byte(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (serial_access_pkg::REG_ADDR[i] == a) begin
                v = regs_q[i];
            end
        end
        return v;
    endfunction

    // frame sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            hdr_q <= 15'h0000;
            rd_q <= 1'b0;
            addr_q <= 15'h0000;
            rx_q <= 7'h00;
        end else if (ce) begin
            if (!cs_act) begin
                state_q <= ST_IDLE;
                cnt_q <= 4'h0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        state_q <= ST_HDR;
                        cnt_q <= 4'h0;
                    end
                    ST_HDR: begin
                        if (rise) begin
                            hdr_q <= hdr_next[14:0];
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == 4'(serial_access_pkg::HDR_BITS - 1)) begin
                                rd_q <= hdr_next[15];
                                addr_q <= hdr_next[14:0];
                                cnt_q <= 4'h0;
                                state_q <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (rise) begin
                            rx_q <= byte_next[6:0];
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q == 4'h7) begin
                                cnt_q <= 4'h0;
                                if (stream_off) begin
                                    state_q <= ST_HOLD;
                                end else begin
                                    addr_q <= addr_step;
                                end
                            end
                        end
                    end
                    ST_HOLD: begin
                        state_q <= ST_HOLD;
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // read data shifter: loaded on the last header or data bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_q <= 8'h00;
        end else if (ce) begin
            if (state_q == ST_HDR && rise
                && cnt_q == 4'(serial_access_pkg::HDR_BITS - 1)) begin
                tx_q <= rd_byte(hdr_next[14:0]);
            end else if (byte_end) begin
                tx_q <= rd_byte(addr_step);
            end else if (state_q == ST_DATA && fall && cnt_q != 4'h0) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // pin drives only in read data bits
    assign link.serial_data_out = tx_q[7];
    assign link.serial_data_out_en_n = ~(state_q == ST_DATA && rd_q && cs_act);

    // register storage, one entry per implemented byte
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                regs_q[i] <= serial_access_pkg::REG_RST[i];
            end else if (ce) begin
                if (serial_access_pkg::REG_RW[i] && wr_fire
                    && addr_q == serial_access_pkg::REG_ADDR[i]) begin
                    regs_q[i] <= byte_next;
                end
            end
        end
    end

    // write notification to the converter core
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_pulse <= 1'b0;
            wr_addr <= 15'h0000;
            wr_data <= 8'h00;
        end else if (ce) begin
            wr_pulse <= wr_fire;
            if (wr_fire) begin
                wr_addr <= addr_q;
                wr_data <= byte_next;
            end
        end
    end

    assign interface_config = regs_q[serial_access_pkg::IDX_IFACE_CFG];
    assign user_serial_options = regs_q[serial_access_pkg::IDX_USER_OPT];
endmodule
`default_nettype wire

// File: verification/serial_access_properties.sv
// link protocol properties for the serial register access port
`timescale 1ns/10ps
`default_nettype none
module serial_access_properties (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sclk,
    input wire logic serial_chip_select_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out_en_n
);
    logic sclk_q;
    logic flag_q;
    logic [7:0] cnt_q;
    logic rise;
    assign rise = sclk && !sclk_q;
    always_ff @(posedge clk_sys) begin
        sclk_q <= srst ? 1'b0 : sclk;
    end
    // rising link clock edges within the current frame
    always_ff @(posedge clk_sys) begin
        if (srst || serial_chip_select_n) begin
            cnt_q <= 8'h00;
        end else if (rise) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else if (rise && cnt_q == 8'h00) begin
            flag_q <= serial_data_in;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_idle_released: assert property (serial_chip_select_n [*8] |-> serial_data_out_en_n)
        else $error("data out driven while deselected");
    a_idle_clock_low: assert property (serial_chip_select_n |-> !sclk)
        else $error("link clock active while deselected");
    a_header_released: assert property (!serial_chip_select_n && cnt_q >= 8'h01
        && cnt_q <= 8'h0F |-> serial_data_out_en_n) else $error("driven during header");
    a_write_released: assert property (!serial_chip_select_n && cnt_q != 8'h00
        && !flag_q |-> serial_data_out_en_n) else $error("driven during write frame");
    a_read_driven: assert property (rise && flag_q && cnt_q >= 8'h10 && cnt_q <= 8'h17
        |-> !serial_data_out_en_n) else $error("read data byte not driven");
    a_data_in_steady: assert property (sclk && $past(sclk) |-> $stable(serial_data_in))
        else $error("data in moved while clock high");
    a_clock_high_min: assert property ($rose(sclk) |-> sclk [*4])
        else $error("link clock high too short");
    a_select_setup: assert property ($fell(serial_chip_select_n) |-> !sclk [*3])
        else $error("clock rose too soon after select");
    a_frame_length: assert property ($rose(serial_chip_select_n)
        |-> cnt_q >= 8'h18 && cnt_q[2:0] == 3'h0) else $error("frame not whole bytes");
    c_read_frame: cover property (rise && flag_q && cnt_q == 8'h17);
    c_stream_write: cover property (rise && !flag_q && cnt_q == 8'h1F);
    c_single_frame: cover property ($rose(serial_chip_select_n) && cnt_q == 8'h18);
endmodule
`default_nettype wire

// File: verification/serial_register_access_port_test.sv
// self-checking bench for host and device ends of the serial port
`timescale 1ns/10ps
`default_nettype none
`define check(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module serial_register_access_port_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [2:0] cmd_addr = 3'h0;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_wr = 1'b0;
    logic cmd_rd = 1'b0;
    logic [15:0] cmd_rdata;
    logic [7:0] interface_config, user_serial_options, wr_data, cfg_b;
    logic wr_pulse;
    logic [14:0] wr_addr;
    int n_mismatch = 0;
    int compares = 0;
    int n_wr = 0;
    int wr_base = 0;
    localparam logic [14:0] RA [8] = '{15'h0000, 15'h0010, 15'h0030, 15'h0031, 15'h002B,
        15'h0068, 15'h0202, 15'h0001};
    localparam logic [7:0] RV [8] = '{8'h30, 8'h00, 8'h00, 8'hA0, 8'h11, 8'h61, 8'h1F, 8'h00};
    serial_link_if lnk();
    serial_link_if lnk_b();
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wr_pulse === 1'b1) n_wr <= n_wr + 1;
    serial_port_host #(.HALF_CYC(12)) u_serial_port_host (.clk_sys(clk_sys), .srst(srst),
        .ce(ce), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_rdata(cmd_rdata), .link(lnk.host));
    serial_port_device u_serial_port_device (.clk_sys(clk_sys), .srst(srst), .ce(ce),
        .link(lnk.device), .interface_config(interface_config),
        .user_serial_options(user_serial_options), .wr_pulse(wr_pulse), .wr_addr(wr_addr),
        .wr_data(wr_data));
    // second device faces a bench driver that may abort frames
    serial_port_device u_serial_port_device_b (.clk_sys(clk_sys), .srst(srst), .ce(ce),
        .link(lnk_b.device), .interface_config(cfg_b), .user_serial_options(),
        .wr_pulse(), .wr_addr(), .wr_data());
    serial_access_properties u_serial_access_properties (.clk_sys(clk_sys), .srst(srst),
        .sclk(lnk.sclk), .serial_chip_select_n(lnk.serial_chip_select_n),
        .serial_data_in(lnk.serial_data_in), .serial_data_out_en_n(lnk.serial_data_out_en_n));
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_wr <= 1'b1;
        @(posedge clk_sys);
        cmd_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        cmd_addr <= a;
        cmd_rd <= 1'b1;
        @(posedge clk_sys);
        cmd_rd <= 1'b0;
        #1;
        d = cmd_rdata;
    endtask
    // one transaction through the host, waiting for busy to drop
    task automatic frame(input logic rd_f, input logic [14:0] a, input logic [7:0] d,
            input logic [7:0] len);
        logic [15:0] s;
        wr(serial_access_pkg::HOST_ADDR, {1'b0, a});
        wr(serial_access_pkg::HOST_TXDATA, {8'h00, d});
        wr(serial_access_pkg::HOST_LEN, {8'h00, len});
        wr(serial_access_pkg::HOST_CTRL, {14'h0000, rd_f, 1'b1});
        s = 16'h0001;
        for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) begin
            rd(serial_access_pkg::HOST_STATUS, s);
        end
        `check(s[0], 1'b0)
    endtask
    task automatic rreg(input logic [14:0] a, input logic [7:0] len, input logic [7:0] e);
        logic [15:0] s;
        frame(1'b1, a, 8'h00, len);
        rd(serial_access_pkg::HOST_RXDATA, s);
        `check(s[7:0], e)
    endtask
    // raw frame of n bits, 125 ns link clock
    task automatic bang(input logic [23:0] f, input int n);
        @(posedge clk_sys);
        lnk_b.serial_chip_select_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            lnk_b.serial_data_in <= f[23 - i];
            repeat (12) @(posedge clk_sys);
            lnk_b.sclk <= 1'b1;
            repeat (13) @(posedge clk_sys);
            lnk_b.sclk <= 1'b0;
        end
        repeat (12) @(posedge clk_sys);
        lnk_b.serial_chip_select_n <= 1'b1;
        lnk_b.serial_data_in <= ~f[24 - n];
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        lnk_b.sclk = 1'b0;
        lnk_b.serial_chip_select_n = 1'b1;
        lnk_b.serial_data_in = 1'b0;
        repeat (10) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
        `check(interface_config, 8'h30)
        for (int i = 0; i < 8; i++) rreg(RA[i], 8'h00, RV[i]);
        frame(1'b0, 15'h0029, 8'h5A, 8'h00);
        `check(wr_addr, 15'h0029)
        `check(wr_data, 8'h5A)
        rreg(15'h0029, 8'h00, 8'h5A);
        wr_base = n_wr;
        frame(1'b0, 15'h0200, 8'h3C, 8'h02);
        `check(n_wr - wr_base, 3)
        rreg(15'h0202, 8'h00, 8'h3C);
        frame(1'b0, 15'h0202, 8'h9E, 8'h00);
        rreg(15'h0200, 8'h02, 8'h9E);
        // descending streams
        frame(1'b0, 15'h0000, 8'h10, 8'h00);
        `check(interface_config, 8'h10)
        frame(1'b0, 15'h0207, 8'h77, 8'h01);
        rreg(15'h0206, 8'h00, 8'h77);
        rreg(15'h0202, 8'h02, 8'h3C);
        frame(1'b0, 15'h0000, 8'h30, 8'h00);
        // streaming switched off
        frame(1'b0, 15'h0010, 8'h01, 8'h00);
        `check(user_serial_options, 8'h01)
        wr_base = n_wr;
        frame(1'b0, 15'h0204, 8'h55, 8'h01);
        `check(n_wr - wr_base, 1)
        rreg(15'h0205, 8'h00, 8'h00);
        rreg(15'h0204, 8'h00, 8'h55);
        frame(1'b0, 15'h0010, 8'h00, 8'h00);
        bang({1'b0, 15'h0000, 8'h34}, 24);
        `check(cfg_b, 8'h34)
        `check(lnk_b.serial_data_out_en_n, 1'b1)
        bang({1'b0, 15'h0000, 8'h00}, 20);
        `check(cfg_b, 8'h34)
        stop_test();
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
